// ==== core/acr_regs.sv ====
// Purpose: Channel 1 gain trim and channel 2 setup, offset and gain trim registers
// Assumes: AXI4-Lite master on i_core_clk, one write and one read in flight at most
// Notes: Unmapped addresses answer SLVERR, reads return zero there
// What this block does
// - Channel 1 gain high register holds gain word bits 23 to 8.
// - Channel 1 gain low register bits 15:8 hold gain word bits 7:0.
// - Channel 2 gain word splits into high register and low register bits 15:8.
// - Channel 2 offset high register holds offset word bits 23 to 8.
// - Channel 2 offset low register bits 15:8 hold offset word bits 7:0.
// - Channel 2 gain high resets to 8000h, other channel 2 trims reset zero.
// - Setup bits 15:6 hold a signed ten-bit channel 2 sample delay.
// - Setup bit 2 set disables channel 2 highpass, clear follows global setting.
// - Setup bits 1:0 pick pins, shorted inputs, positive or negative test signal.
// - Setup register resets to zero.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module acr_regs (
   // Clock, reset, enable
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // AXI4-Lite write address and data
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   // Global highpass control from the wider device
   input wire logic [3:0] i_global_highpass_setting,
   // Trim and setup values to the converter
   output logic [23:0] o_first_channel_gain_trim,
   output logic [23:0] o_second_channel_gain_trim,
   output logic [23:0] o_second_channel_offset_trim,
   output logic [9:0] o_second_channel_sample_delay,
   output logic o_second_channel_highpass_off,
   output logic [1:0] o_second_channel_input_select,
   output logic [3:0] o_second_channel_highpass_setting
);
   logic rst_meta_q;
   logic rst_sync_q;

   // Register storage
   logic [15:0] ch1_gain_high_q, ch1_gain_high_d;
   logic [7:0] ch1_gain_low_q, ch1_gain_low_d;
   logic [15:0] ch2_offset_high_q, ch2_offset_high_d;
   logic [7:0] ch2_offset_low_q, ch2_offset_low_d;
   logic [15:0] ch2_gain_high_q, ch2_gain_high_d;
   logic [7:0] ch2_gain_low_q, ch2_gain_low_d;
   logic [9:0] delay_q, delay_d;
   logic hp_off_q, hp_off_d;
   logic [1:0] in_sel_q, in_sel_d;
   logic [3:0] hp_eff_q, hp_eff_d;

   // Write channel state
   logic aw_held_q, aw_held_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic w_held_q, w_held_d;
   logic [15:0] w_data_q, w_data_d;
   logic [1:0] w_strb_q, w_strb_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic do_write;

   // Read channel state
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   // Mapped register check on a byte address
   function automatic logic addr_hit(input logic [7:0] addr);
      logic [5:0] idx;
      idx = addr[7:2];
      return (addr[1:0] == 2'h0) &&
         (idx >= acr_regs_pkg::IDX_CH1_GAIN_HIGH) &&
         (idx <= acr_regs_pkg::IDX_CH2_GAIN_LOW);
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [1:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = nw[7:0];
      end
      if (strb[1]) begin
         r[15:8] = nw[15:8];
      end
      return r;
   endfunction

   // Assembled 16-bit register images; reserved bits are zero
   logic [15:0] img_ch1_gain_low, img_setup, img_ch2_offset_low, img_ch2_gain_low;
   assign img_ch1_gain_low = {ch1_gain_low_q, 8'h00};
   assign img_ch2_offset_low = {ch2_offset_low_q, 8'h00};
   assign img_ch2_gain_low = {ch2_gain_low_q, 8'h00};
   assign img_setup = {delay_q, 3'h0, hp_off_q, in_sel_q};

   function automatic logic [15:0] read_img(input logic [5:0] idx, input logic [15:0] g1h,
      input logic [15:0] g1l, input logic [15:0] st, input logic [15:0] o2h,
      input logic [15:0] o2l, input logic [15:0] g2h, input logic [15:0] g2l);
      logic [15:0] r;
      r = 16'h0000;
      unique case (idx)
         acr_regs_pkg::IDX_CH1_GAIN_HIGH: r = g1h;
         acr_regs_pkg::IDX_CH1_GAIN_LOW: r = g1l;
         acr_regs_pkg::IDX_CH2_SETUP: r = st;
         acr_regs_pkg::IDX_CH2_OFFSET_HIGH: r = o2h;
         acr_regs_pkg::IDX_CH2_OFFSET_LOW: r = o2l;
         acr_regs_pkg::IDX_CH2_GAIN_HIGH: r = g2h;
         acr_regs_pkg::IDX_CH2_GAIN_LOW: r = g2l;
         default: r = 16'h0000;
      endcase
      return r;
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign do_write = aw_held_q && w_held_q && !bvalid_q;

   // Write channel
   always_comb begin
      aw_held_d = aw_held_q;
      aw_addr_d = aw_addr_q;
      w_held_d = w_held_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (i_s_axi_awvalid && awready_q) begin
         aw_held_d = 1'b1;
         aw_addr_d = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && wready_q) begin
         w_held_d = 1'b1;
         w_data_d = i_s_axi_wdata[15:0];
         w_strb_d = i_s_axi_wstrb[1:0];
      end
      if (do_write) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = addr_hit(aw_addr_q) ? acr_regs_pkg::RESP_OKAY : acr_regs_pkg::RESP_SLVERR;
      end else if (bvalid_q && i_s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      awready_d = !aw_held_d;
      wready_d = !w_held_d;
   end

   always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_held_q <= 1'b0;
         w_data_q <= 16'h0000;
         w_strb_q <= 2'h0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= acr_regs_pkg::RESP_OKAY;
      end else if (i_clk_en) begin
         aw_held_q <= aw_held_d;
         aw_addr_q <= aw_addr_d;
         w_held_q <= w_held_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   // Register file updates
   always_comb begin
      logic [15:0] m;
      m = 16'h0000;
      ch1_gain_high_d = ch1_gain_high_q;
      ch1_gain_low_d = ch1_gain_low_q;
      ch2_offset_high_d = ch2_offset_high_q;
      ch2_offset_low_d = ch2_offset_low_q;
      ch2_gain_high_d = ch2_gain_high_q;
      ch2_gain_low_d = ch2_gain_low_q;
      delay_d = delay_q;
      hp_off_d = hp_off_q;
      in_sel_d = in_sel_q;
      if (do_write && addr_hit(aw_addr_q)) begin
         m = merge(read_img(aw_addr_q[7:2], ch1_gain_high_q, img_ch1_gain_low, img_setup,
                   ch2_offset_high_q, img_ch2_offset_low, ch2_gain_high_q, img_ch2_gain_low),
                   w_data_q, w_strb_q);
         unique case (aw_addr_q[7:2])
            acr_regs_pkg::IDX_CH1_GAIN_HIGH: ch1_gain_high_d = m;
            acr_regs_pkg::IDX_CH1_GAIN_LOW: ch1_gain_low_d = m[15:8];
            acr_regs_pkg::IDX_CH2_SETUP: begin
               delay_d = m[15:6];
               hp_off_d = m[acr_regs_pkg::POS_HIGHPASS_OFF];
               in_sel_d = m[1:0];
            end
            acr_regs_pkg::IDX_CH2_OFFSET_HIGH: ch2_offset_high_d = m;
            acr_regs_pkg::IDX_CH2_OFFSET_LOW: ch2_offset_low_d = m[15:8];
            acr_regs_pkg::IDX_CH2_GAIN_HIGH: ch2_gain_high_d = m;
            acr_regs_pkg::IDX_CH2_GAIN_LOW: ch2_gain_low_d = m[15:8];
            default: m = 16'h0000;
         endcase
      end
      // Channel 2 highpass follows the global setting unless locally disabled
      hp_eff_d = hp_off_d ? 4'h0 : i_global_highpass_setting;
   end

   always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         ch1_gain_high_q <= acr_regs_pkg::RST_CH1_GAIN_HIGH;
         ch1_gain_low_q <= acr_regs_pkg::RST_CH1_GAIN_LOW;
         ch2_offset_high_q <= acr_regs_pkg::RST_CH2_OFFSET_HIGH;
         ch2_offset_low_q <= acr_regs_pkg::RST_CH2_OFFSET_LOW;
         ch2_gain_high_q <= acr_regs_pkg::RST_CH2_GAIN_HIGH;
         ch2_gain_low_q <= acr_regs_pkg::RST_CH2_GAIN_LOW;
         delay_q <= acr_regs_pkg::RST_SAMPLE_DELAY;
         hp_off_q <= acr_regs_pkg::RST_HIGHPASS_OFF;
         in_sel_q <= acr_regs_pkg::RST_INPUT_SELECT;
         hp_eff_q <= 4'h0;
      end else if (i_clk_en) begin
         ch1_gain_high_q <= ch1_gain_high_d;
         ch1_gain_low_q <= ch1_gain_low_d;
         ch2_offset_high_q <= ch2_offset_high_d;
         ch2_offset_low_q <= ch2_offset_low_d;
         ch2_gain_high_q <= ch2_gain_high_d;
         ch2_gain_low_q <= ch2_gain_low_d;
         delay_q <= delay_d;
         hp_off_q <= hp_off_d;
         in_sel_q <= in_sel_d;
         hp_eff_q <= hp_eff_d;
      end
   end

   // Read channel
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (i_s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rdata_d = {16'h0000, read_img(i_s_axi_araddr[7:2], ch1_gain_high_q, img_ch1_gain_low,
                    img_setup, ch2_offset_high_q, img_ch2_offset_low, ch2_gain_high_q,
                    img_ch2_gain_low)};
         if (!addr_hit(i_s_axi_araddr)) begin
            rdata_d = 32'h0000_0000;
         end
         rresp_d = addr_hit(i_s_axi_araddr) ? acr_regs_pkg::RESP_OKAY :
                   acr_regs_pkg::RESP_SLVERR;
      end else if (rvalid_q && i_s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      arready_d = !rvalid_d;
   end

   always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= acr_regs_pkg::RESP_OKAY;
      end else if (i_clk_en) begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign o_s_axi_awready = awready_q;
   assign o_s_axi_wready = wready_q;
   assign o_s_axi_bvalid = bvalid_q;
   assign o_s_axi_bresp = bresp_q;
   assign o_s_axi_arready = arready_q;
   assign o_s_axi_rvalid = rvalid_q;
   assign o_s_axi_rdata = rdata_q;
   assign o_s_axi_rresp = rresp_q;
   assign o_first_channel_gain_trim = {ch1_gain_high_q, ch1_gain_low_q};
   assign o_second_channel_gain_trim = {ch2_gain_high_q, ch2_gain_low_q};
   assign o_second_channel_offset_trim = {ch2_offset_high_q, ch2_offset_low_q};
   assign o_second_channel_sample_delay = delay_q;
   assign o_second_channel_highpass_off = hp_off_q;
   assign o_second_channel_input_select = in_sel_q;
   assign o_second_channel_highpass_setting = hp_eff_q;
endmodule

// ==== pkg/acr_regs_pkg.sv ====
// Purpose: Constants for the channel calibration and configuration register bank
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes: Offsets are register indices; data sits in the low 16 bits of each word
package acr_regs_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 16;
   // Register indices
   localparam logic [5:0] IDX_CH1_GAIN_HIGH = 6'h11;
   localparam logic [5:0] IDX_CH1_GAIN_LOW = 6'h12;
   localparam logic [5:0] IDX_CH2_SETUP = 6'h13;
   localparam logic [5:0] IDX_CH2_OFFSET_HIGH = 6'h14;
   localparam logic [5:0] IDX_CH2_OFFSET_LOW = 6'h15;
   localparam logic [5:0] IDX_CH2_GAIN_HIGH = 6'h16;
   localparam logic [5:0] IDX_CH2_GAIN_LOW = 6'h17;
   // Values after reset
   localparam logic [15:0] RST_CH1_GAIN_HIGH = 16'h8000;
   localparam logic [7:0] RST_CH1_GAIN_LOW = 8'h00;
   localparam logic [15:0] RST_CH2_GAIN_HIGH = 16'h8000;
   localparam logic [7:0] RST_CH2_GAIN_LOW = 8'h00;
   localparam logic [15:0] RST_CH2_OFFSET_HIGH = 16'h0000;
   localparam logic [7:0] RST_CH2_OFFSET_LOW = 8'h00;
   localparam logic [9:0] RST_SAMPLE_DELAY = 10'h000;
   localparam logic RST_HIGHPASS_OFF = 1'b0;
   localparam logic [1:0] RST_INPUT_SELECT = 2'h0;
   // Field positions
   localparam int unsigned POS_LOW_BYTE = 8;
   localparam int unsigned POS_SAMPLE_DELAY = 6;
   localparam int unsigned POS_HIGHPASS_OFF = 2;
   localparam int unsigned POS_INPUT_SELECT = 0;
   // Input select codes
   localparam logic [1:0] SEL_PIN_PAIR = 2'h0;
   localparam logic [1:0] SEL_SHORTED = 2'h1;
   localparam logic [1:0] SEL_TEST_POS = 2'h2;
   localparam logic [1:0] SEL_TEST_NEG = 2'h3;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== testbench/acr_regs_sva.sv ====
// Purpose: Bus and highpass checks on the trim register bank
// Assumes: Outputs are valid from the fourth edge after reset release
// Notes: Checks start once four edges have passed, so $past never sees reset-time values
`timescale 1ns/1ps
module acr_regs_sva (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Bus
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic [31:0] o_s_axi_rdata,
   // Highpass
   input wire logic [3:0] i_global_highpass_setting,
   input wire logic o_second_channel_highpass_off,
   input wire logic [3:0] o_second_channel_highpass_setting
);
   logic [2:0] live_q;
   logic [2:0] live_d;
   always_comb begin
      live_d = (live_q == 3'h4) ? live_q : live_q + 3'h1;
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         live_q <= 3'h0;
      end else begin
         live_q <= live_d;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n || live_q != 3'h4);
   sequence s_aw_w;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
   endsequence
   sequence s_ar;
      i_s_axi_arvalid && o_s_axi_arready;
   endsequence
   a_write_answer: assert property (s_aw_w |-> ##[1:2] o_s_axi_bvalid)
      else $error("write not answered");
   a_read_answer: assert property (s_ar |=> o_s_axi_rvalid)
      else $error("read not answered");
   a_bvalid_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
      else $error("bvalid dropped early");
   a_rdata_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
      o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data moved");
   a_ar_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("arready during read answer");
   a_aw_blocked: assert property (s_aw_w |=> !o_s_axi_awready && !o_s_axi_wready)
      else $error("write ready while a write is held");
   a_upper_zero: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0)
      else $error("upper read bits set");
   a_hp_zero: assert property (o_second_channel_highpass_off &&
      $past(o_second_channel_highpass_off) |-> o_second_channel_highpass_setting == 4'h0)
      else $error("highpass not off");
   a_hp_follow: assert property (!o_second_channel_highpass_off &&
      !$past(o_second_channel_highpass_off) |->
      o_second_channel_highpass_setting == $past(i_global_highpass_setting))
      else $error("highpass not following global");
endmodule
bind acr_regs acr_regs_sva u_sva (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
   .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
   .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
   .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
   .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
   .o_s_axi_rdata(o_s_axi_rdata), .i_global_highpass_setting(i_global_highpass_setting),
   .o_second_channel_highpass_off(o_second_channel_highpass_off),
   .o_second_channel_highpass_setting(o_second_channel_highpass_setting));

// ==== testbench/acr_regs_tb.sv ====
// Purpose: Self-checking bench for the trim register bank
// Assumes: Ready signals rise on the third edge past reset release
// Notes: Readback and port values come from a shadow copy
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   checked++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
   end \
end
module acr_regs_tb;
   localparam logic [15:0] INIT [7] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h8000, 16'h0000};
   localparam logic [15:0] MSK [7] = '{16'hffff, 16'hff00, 16'hffc7, 16'hffff,
      16'hff00, 16'hffff, 16'hff00};
   logic clk, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, ed;
   logic [3:0] wstrb = 0, ghp = 0, hps;
   logic awready, wready, bvalid, arready, rvalid, hpoff;
   logic [1:0] bresp, rresp, sel;
   logic [23:0] g1, g2, o2;
   logic [9:0] dly;
   logic [15:0] mdl [7] = INIT;
   logic [31:0] exp_d[$];
   logic [1:0] exp_r[$];
   logic [1:0] exp_b[$];
   int fails = 0;
   int checked = 0;
   acr_regs uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_global_highpass_setting(ghp),
      .o_first_channel_gain_trim(g1), .o_second_channel_gain_trim(g2),
      .o_second_channel_offset_trim(o2), .o_second_channel_sample_delay(dly),
      .o_second_channel_highpass_off(hpoff), .o_second_channel_input_select(sel),
      .o_second_channel_highpass_setting(hps));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) ghp <= 4'($urandom);
   // Result watcher
   always @(posedge clk) begin
      if (bvalid === 1'b1 && bready === 1'b1) begin
         ed = 32'(exp_b.pop_front());
         `CHK("bresp", ed[1:0], bresp)
      end
      if (rvalid === 1'b1 && rready === 1'b1) begin
         ed = exp_d.pop_front();
         `CHK("rdata", ed, rdata)
         ed = 32'(exp_r.pop_front());
         `CHK("rresp", ed[1:0], rresp)
      end
   end
   task automatic summarize();
      if (fails == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      int i;
      bit ok, pa, pw, hs;
      logic [15:0] bm;
      logic [1:0] r;
      @(posedge clk);
      ok = a[1:0] == 2'h0 && a >= 8'h44 && a <= 8'h5c;
      i = ok ? int'((a - 8'h44) >> 2) : 0;
      bm = {{8{s[1]}}, {8{s[0]}}} & MSK[i] & {16{ok}};
      r = ok ? acr_regs_pkg::RESP_OKAY : acr_regs_pkg::RESP_SLVERR;
      if (w) begin
         mdl[i] = (mdl[i] & ~bm) | (d[15:0] & bm);
         exp_b.push_back(r);
         awaddr <= a;
         wdata <= d;
         wstrb <= s;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         exp_d.push_back(ok ? {16'h0, mdl[i]} : 32'h0);
         exp_r.push_back(r);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      pa = 1;
      pw = w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         pa = pa && !(w ? awready : arready);
         pw = pw && !wready;
         hs = w ? bvalid && bready : rvalid && rready;
         if (w) awvalid <= pa;
         else arvalid <= pa;
         wvalid <= pw;
         bready <= w && !hs;
         rready <= !w && !hs;
      end while (!hs && n < 40);
      if (!hs) begin
         fails++;
         summarize();
      end
   endtask
   task automatic chk_out();
      `CHK("ch1 gain", {mdl[0], mdl[1][15:8]}, g1)
      `CHK("ch2 offset", {mdl[3], mdl[4][15:8]}, o2)
      `CHK("ch2 gain", {mdl[5], mdl[6][15:8]}, g2)
      `CHK("delay", mdl[2][15:6], dly)
      `CHK("hp off", mdl[2][2], hpoff)
      `CHK("in sel", mdl[2][1:0], sel)
   endtask
   task automatic boot();
      int k;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      mdl = INIT;
      for (k = 0; k < 8; k++) bus(0, 8'h44 + 8'(4 * k), 0, 0);
      chk_out();
   endtask
   initial begin
      int k;
      logic [31:0] d;
      k = $urandom(19624);
      boot();
      for (k = 0; k < 4; k++) begin
         d = $urandom;
         d[2:0] = {k[0], k[1:0]};
         bus(1, 8'h4c, d, 4'h3);
         bus(0, 8'h4c, 0, 0);
         chk_out();
      end
      for (k = 0; k < 40; k++) begin
         d = 32'h40 + 32'(4 * ($urandom % 8));
         bus(1, d[7:0], $urandom, 4'($urandom));
         bus(0, d[7:0], 0, 0);
      end
      chk_out();
      bus(1, 8'h46, 32'hffff, 4'hf);
      bus(0, 8'h46, 0, 0);
      bus(0, 8'h60, 0, 0);
      rst_n <= 1'b0;
      boot();
      summarize();
   end
endmodule
